// File: common/mdcf_pkg.sv
package mdcf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MDCF_OFS_TX_CTRL  = 8'h00;
  localparam logic [7:0] MDCF_OFS_RX_CTRL  = 8'h04;
  localparam logic [7:0] MDCF_OFS_TX_START = 8'h08;
  localparam logic [7:0] MDCF_OFS_RX_START = 8'h0c;
  localparam logic [7:0] MDCF_OFS_TX_BASE  = 8'h10;
  localparam logic [7:0] MDCF_OFS_RX_BASE  = 8'h14;
  localparam logic [7:0] MDCF_OFS_HASH_LO  = 8'h20;
  localparam logic [7:0] MDCF_OFS_HASH_HI  = 8'h24;
  localparam logic [7:0] MDCF_OFS_STATUS   = 8'h30;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MDCF_TXC_ENABLE_BIT = 0;
  localparam int MDCF_RXC_ENABLE_BIT = 0;
  localparam int MDCF_RXC_HASH_BIT   = 1;
  localparam int MDCF_RXC_ALL_BIT    = 2;
  localparam int MDCF_RXC_ALL_MC_BIT = 5;
  localparam int MDCF_STAT_TX_LSB    = 0;
  localparam int MDCF_STAT_RX_LSB    = 2;
  localparam logic [31:0] MDCF_REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Hash filter
  // ----------------------------------------------------------------
  localparam logic [31:0] MDCF_CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] MDCF_CRC_INIT = 32'hffff_ffff;
  localparam int MDCF_HASH_IDX_W   = 6;
  localparam int MDCF_HASH_WORD_BIT = 5;
  localparam int MDCF_DA_W         = 48;

  // ----------------------------------------------------------------
  // Process states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MDCF_STOPPED,
    MDCF_RUNNING,
    MDCF_SUSPENDED
  } mdcf_proc_t;

endpackage

// File: hdl/mdcf_dma_proc.sv
`timescale 1ns/10ps
`default_nettype none
module mdcf_dma_proc
  import mdcf_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  enable_i,
  input  wire logic  start_i,
  input  wire logic  desc_avail_i,
  input  wire logic  busy_i,
  output mdcf_proc_t state_o,
  output logic       fetch_o
);

  typedef struct packed
  {
    mdcf_proc_t state;
    logic       fetch;
  } mdcf_proc_regs_t;

  mdcf_proc_regs_t s_q;
  mdcf_proc_regs_t s_d;

  // ----------------------------------------------------------------
  // Process sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d       = s_q;
    s_d.fetch = 1'b0;
    case (s_q.state)
      MDCF_STOPPED:
        if (enable_i)
        begin
          s_d.fetch = 1'b1;
          s_d.state = MDCF_RUNNING;
        end
      MDCF_RUNNING:
        // Stop only between frames, never mid-frame
        if (!enable_i && !busy_i)
          s_d.state = MDCF_STOPPED;
        else if (start_i)
          s_d.fetch = 1'b1;
        else if (!desc_avail_i && !busy_i)
          s_d.state = MDCF_SUSPENDED;
      MDCF_SUSPENDED:
        if (!enable_i)
          s_d.state = MDCF_STOPPED;
        else if (start_i)
        begin
          s_d.fetch = 1'b1;
          s_d.state = desc_avail_i ? MDCF_RUNNING : MDCF_SUSPENDED;
        end
      default:
        s_d.state = MDCF_STOPPED;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '{state: MDCF_STOPPED, fetch: 1'b0};
    else
      s_q <= s_d;
  end

  assign state_o = s_q.state;
  assign fetch_o = s_q.fetch;

endmodule
`default_nettype wire

// File: hdl/mdcf_hash_filter.sv
`timescale 1ns/10ps
`default_nettype none
module mdcf_hash_filter
  import mdcf_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        da_valid_i,
  input  wire logic [47:0] da_i,
  input  wire logic [31:0] table_lo_i,
  input  wire logic [31:0] table_hi_i,
  input  wire logic        hash_en_i,
  input  wire logic        all_i,
  input  wire logic        all_mc_i,
  output logic             done_o,
  output logic             accept_o,
  output logic [5:0]       index_o
);

  typedef struct packed
  {
    logic       done;
    logic       accept;
    logic [5:0] index;
  } mdcf_hash_regs_t;

  mdcf_hash_regs_t s_q;
  mdcf_hash_regs_t s_d;

  // ----------------------------------------------------------------
  // CRC over the address, first octet first, each octet LSB first
  // ----------------------------------------------------------------
  function automatic logic [31:0] da_crc(input logic [47:0] da);
    logic [31:0] crc;
    logic        fb;
    crc = MDCF_CRC_INIT;
    for (int i = 0; i < MDCF_DA_W; i++)
    begin
      fb  = crc[31] ^ da[i];
      crc = {crc[30:0], 1'b0} ^ (fb ? MDCF_CRC_POLY : 32'h0000_0000);
    end
    return crc;
  endfunction

  logic [31:0] crc;
  logic [5:0]  idx;
  logic [31:0] word;
  logic        group;

  always_comb
  begin
    crc   = da_crc(da_i);
    idx   = crc[31 -: MDCF_HASH_IDX_W];
    word  = idx[MDCF_HASH_WORD_BIT] ? table_hi_i : table_lo_i;
    group = da_i[0];
    s_d        = s_q;
    s_d.done   = da_valid_i;
    if (da_valid_i)
    begin
      s_d.index  = idx;
      // Broadcast is a group address, so all-multicast covers it
      s_d.accept = group && (all_i || all_mc_i
                   || (hash_en_i && word[idx[4:0]]));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done_o   = s_q.done;
  assign accept_o = s_q.accept;
  assign index_o  = s_q.index;

endmodule
`default_nettype wire

// File: hdl/mdcf_top.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module mdcf_top
  import mdcf_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADR_W  = 8
)
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // Transmit DMA datapath
  input  wire logic              tx_desc_avail_i,
  input  wire logic              tx_busy_i,
  output logic                   tx_start_pulse_o,
  output logic                   tx_fetch_o,
  output mdcf_proc_t             tx_state_o,
  output logic      [31:0]       tx_list_start_address_o,
  // Receive DMA datapath
  input  wire logic              rx_desc_avail_i,
  input  wire logic              rx_busy_i,
  output logic                   rx_start_pulse_o,
  output logic                   rx_fetch_o,
  output mdcf_proc_t             rx_state_o,
  output logic      [31:0]       rx_list_start_address_o,
  // Destination address filter
  input  wire logic              da_valid_i,
  input  wire logic [47:0]       da_i,
  output logic                   filter_done_o,
  output logic                   filter_accept_o,
  output logic      [5:0]        filter_index_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 32)
  begin : g_bad_data
    $error("mdcf_top: data width must be 32");
  end
  if (ADR_W < 8)
  begin : g_bad_adr
    $error("mdcf_top: address needs at least 8 bits");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic        ack;
    logic [31:0] rdata;
    logic        tx_ctrl_en;
    logic [5:0]  rx_ctrl;
    logic [31:0] tx_base;
    logic [31:0] rx_base;
    logic [31:0] hash_lo;
    logic [31:0] hash_hi;
    logic        tx_pulse;
    logic        rx_pulse;
  } mdcf_regs_t;

  mdcf_regs_t s_q;
  mdcf_regs_t s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_sel(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic adr_is(
    input logic [ADR_W-1:0] adr,
    input logic [7:0]       ofs
  );
    // Shift, not a part-select, so an 8-bit address needs no empty range
    return (adr[7:2] == ofs[7:2]) && ((adr >> 8) == '0);
  endfunction

  // ----------------------------------------------------------------
  // Process sequencers and filter
  // ----------------------------------------------------------------
  mdcf_proc_t tx_state;
  mdcf_proc_t rx_state;
  logic       tx_fetch;
  logic       rx_fetch;

  mdcf_dma_proc u_tx_proc
  (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .enable_i     (s_q.tx_ctrl_en),
    .start_i      (s_q.tx_pulse),
    .desc_avail_i (tx_desc_avail_i),
    .busy_i       (tx_busy_i),
    .state_o      (tx_state),
    .fetch_o      (tx_fetch)
  );

  mdcf_dma_proc u_rx_proc
  (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .enable_i     (s_q.rx_ctrl[MDCF_RXC_ENABLE_BIT]),
    .start_i      (s_q.rx_pulse),
    .desc_avail_i (rx_desc_avail_i),
    .busy_i       (rx_busy_i),
    .state_o      (rx_state),
    .fetch_o      (rx_fetch)
  );

  mdcf_hash_filter u_filter
  (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .da_valid_i (da_valid_i),
    .da_i       (da_i),
    .table_lo_i (s_q.hash_lo),
    .table_hi_i (s_q.hash_hi),
    .hash_en_i  (s_q.rx_ctrl[MDCF_RXC_HASH_BIT]),
    .all_i      (s_q.rx_ctrl[MDCF_RXC_ALL_BIT]),
    .all_mc_i   (s_q.rx_ctrl[MDCF_RXC_ALL_MC_BIT]),
    .done_o     (filter_done_o),
    .accept_o   (filter_accept_o),
    .index_o    (filter_index_o)
  );

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic [31:0] status;

  always_comb
  begin
    // One request per bus cycle; ack gates the repeat
    req    = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr     = req && wb_we_i;
    rd     = req && !wb_we_i;
    status = MDCF_REG_RESET;
    status[MDCF_STAT_TX_LSB +: 2] = tx_state;
    status[MDCF_STAT_RX_LSB +: 2] = rx_state;

    s_d          = s_q;
    s_d.ack      = req;
    s_d.tx_pulse = 1'b0;
    s_d.rx_pulse = 1'b0;
    if (rd)
      s_d.rdata = MDCF_REG_RESET;

    if (adr_is(wb_adr_i, MDCF_OFS_TX_CTRL))
    begin
      if (wr && wb_sel_i[0])
        s_d.tx_ctrl_en = wb_dat_i[MDCF_TXC_ENABLE_BIT];
      if (rd)
        s_d.rdata[MDCF_TXC_ENABLE_BIT] = s_q.tx_ctrl_en;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_RX_CTRL))
    begin
      if (wr && wb_sel_i[0])
        s_d.rx_ctrl = wb_dat_i[5:0];
      if (rd)
        s_d.rdata[5:0] = s_q.rx_ctrl;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_TX_START))
    begin
      // Data is ignored; only the write itself matters
      if (wr)
        s_d.tx_pulse = 1'b1;
      // Reads stay zero, nothing is stored
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_RX_START))
    begin
      if (wr)
        s_d.rx_pulse = 1'b1;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_TX_BASE))
    begin
      // Writes outside the stopped state are dropped
      if (wr && tx_state == MDCF_STOPPED)
        s_d.tx_base = merge_sel(s_q.tx_base, wb_dat_i, wb_sel_i);
      if (rd)
        s_d.rdata = s_q.tx_base;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_RX_BASE))
    begin
      if (wr && rx_state == MDCF_STOPPED)
        s_d.rx_base = merge_sel(s_q.rx_base, wb_dat_i, wb_sel_i);
      if (rd)
        s_d.rdata = s_q.rx_base;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_HASH_LO))
    begin
      if (wr)
        s_d.hash_lo = merge_sel(s_q.hash_lo, wb_dat_i, wb_sel_i);
      if (rd)
        s_d.rdata = s_q.hash_lo;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_HASH_HI))
    begin
      if (wr)
        s_d.hash_hi = merge_sel(s_q.hash_hi, wb_dat_i, wb_sel_i);
      if (rd)
        s_d.rdata = s_q.hash_hi;
    end
    else if (adr_is(wb_adr_i, MDCF_OFS_STATUS))
    begin
      if (rd)
        s_d.rdata = status;
    end
    // Unmapped: acked, writes dropped, reads zero
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o                = s_q.ack;
  assign wb_dat_o                = s_q.rdata;
  assign tx_start_pulse_o        = s_q.tx_pulse;
  assign rx_start_pulse_o        = s_q.rx_pulse;
  assign tx_list_start_address_o = s_q.tx_base;
  assign rx_list_start_address_o = s_q.rx_base;
  assign tx_fetch_o              = tx_fetch;
  assign rx_fetch_o              = rx_fetch;
  assign tx_state_o              = tx_state;
  assign rx_state_o              = rx_state;

endmodule
`default_nettype wire

// File: sim/mdcf_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mdcf_top_assertions
  import mdcf_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADR_W  = 8
)
(
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADR_W-1:0]  wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              tx_start_pulse_o,
  input wire logic              rx_start_pulse_o,
  input wire logic              tx_fetch_o,
  input wire logic              rx_desc_avail_i,
  input wire mdcf_proc_t        tx_state_o,
  input wire mdcf_proc_t        rx_state_o,
  input wire logic [31:0]       tx_list_start_address_o,
  input wire logic              da_valid_i,
  input wire logic [47:0]       da_i,
  input wire logic              filter_done_o,
  input wire logic              filter_accept_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Request taken at this edge
  sequence s_take(logic [5:0] w, logic wr);
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i == wr && wb_adr_i[7:2] == w;
  endsequence

  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_TX_START: assert property (s_take(6'h02, 1'b1) |=> tx_start_pulse_o)
    else $error("no transmit start pulse");
  AST_RX_START: assert property (s_take(6'h03, 1'b1) |=> rx_start_pulse_o)
    else $error("no receive start pulse");
  AST_START_RD_ZERO: assert property (s_take(6'h02, 1'b0) or s_take(6'h03, 1'b0) |=> wb_dat_o == '0)
    else $error("start register read not zero");
  AST_TX_PULSE_ONE: assert property (tx_start_pulse_o |-> wb_ack_o ##1 !tx_start_pulse_o)
    else $error("transmit start pulse not single");
  AST_TX_FETCH: assert property (tx_start_pulse_o && tx_state_o != MDCF_STOPPED |=> tx_fetch_o)
    else $error("transmit start gave no poll");
  AST_RX_RESUME: assert property (rx_start_pulse_o && rx_state_o == MDCF_SUSPENDED |=>
    rx_state_o == ($past(rx_desc_avail_i) ? MDCF_RUNNING : MDCF_SUSPENDED))
    else $error("receive resume state wrong");
  AST_BASE_LOCK: assert property (tx_state_o != MDCF_STOPPED |=> $stable(tx_list_start_address_o))
    else $error("transmit base changed while active");
  AST_FILT_DONE: assert property (da_valid_i |=> filter_done_o)
    else $error("filter result late");
  AST_UNICAST: assert property (da_valid_i && !da_i[0] |=> !filter_accept_o)
    else $error("unicast frame accepted");
endmodule

bind mdcf_top mdcf_top_assertions #(.DATA_W(DATA_W), .ADR_W(ADR_W)) u_chk (.mclk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .tx_start_pulse_o,
  .rx_start_pulse_o, .tx_fetch_o, .rx_desc_avail_i, .tx_state_o, .rx_state_o,
  .tx_list_start_address_o, .da_valid_i, .da_i, .filter_done_o, .filter_accept_o);
`default_nettype wire

// File: sim/mdcf_dp_model.sv
`timescale 1ns/10ps
`default_nettype none
module mdcf_dp_model
#(
  parameter int LAT = 4
)
(
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic fetch_i,
  input  wire logic have_i,
  output logic      avail_o,
  output logic      busy_o
);
  // Busy for LAT cycles per fetched frame; slow instance exercises waits
  int cnt_q;
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= 0;
    else if (fetch_i && have_i)
      cnt_q <= LAT;
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end
  assign busy_o  = (cnt_q != 0);
  assign avail_o = have_i;
endmodule
`default_nettype wire

// File: sim/mac_dma_command_and_hash_filter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mac_dma_command_and_hash_filter_tb;
  import mdcf_pkg::*;
  logic        mclk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, da_valid, fdone, facc;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [47:0] da;
  logic [5:0]  fidx;
  logic [1:0]  have, fetch, avail, busy, spulse;
  logic [31:0] base [2];
  logic [31:0] mdl [16];
  mdcf_proc_t  state [2];
  int          mismatches, checks;
  int          fcnt [2], scnt [2];

  mdcf_top mdcf_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tx_desc_avail_i(avail[0]), .tx_busy_i(busy[0]),
    .tx_start_pulse_o(spulse[0]), .tx_fetch_o(fetch[0]), .tx_state_o(state[0]),
    .tx_list_start_address_o(base[0]), .rx_desc_avail_i(avail[1]), .rx_busy_i(busy[1]),
    .rx_start_pulse_o(spulse[1]), .rx_fetch_o(fetch[1]), .rx_state_o(state[1]),
    .rx_list_start_address_o(base[1]), .da_valid_i(da_valid), .da_i(da),
    .filter_done_o(fdone), .filter_accept_o(facc), .filter_index_o(fidx));
  mdcf_dp_model #(.LAT(6)) mdcf_dp_model_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .fetch_i(fetch[0]), .have_i(have[0]), .avail_o(avail[0]), .busy_o(busy[0]));
  mdcf_dp_model #(.LAT(1)) mdcf_dp_model_rx_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .fetch_i(fetch[1]), .have_i(have[1]), .avail_o(avail[1]), .busy_o(busy[1]));

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    mdcf_proc_t st;
    n = 0;
    @(posedge mclk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do
    begin
      @(posedge mclk_i);
      if (n == 0)
        st = state[a[2]];
      n++;
    end
    while (wb_ack !== 1'b1 && n < 16);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(32'(wb_ack), 32'h1);
    if (w && (a[5] || (a[4] && st == MDCF_STOPPED)))
      mdl[a[5:2]] = d;
  endtask

  task automatic rdchk(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rd, mdl[a[5:2]]);
  endtask

  task automatic proc_test(input int p);
    logic [7:0] o;
    o = 8'(4 * p);
    bus(1'b1, 8'h08 + o, $urandom, 4'($urandom));
    bus(1'b1, 8'h10 + o, $urandom & 32'hffff_fffc, 4'hf);
    rdchk(8'h10 + o);
    have[p] <= 1'b1;
    bus(1'b1, o, 32'h1, 4'h1);
    repeat (3) @(posedge mclk_i);
    chk(32'(state[p]), 32'(MDCF_RUNNING));
    bus(1'b1, 8'h10 + o, $urandom, 4'hf);
    rdchk(8'h10 + o);
    chk(base[p], mdl[4 + p]);
    have[p] <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk(32'(state[p]), 32'(MDCF_SUSPENDED));
    bus(1'b1, 8'h08 + o, $urandom, 4'($urandom));
    repeat (4) @(posedge mclk_i);
    chk(32'(state[p]), 32'(MDCF_SUSPENDED));
    have[p] <= 1'b1;
    bus(1'b1, 8'h08 + o, $urandom, 4'($urandom));
    repeat (2) @(posedge mclk_i);
    chk(32'(state[p]), 32'(MDCF_RUNNING));
    rdchk(8'h08 + o);
    bus(1'b1, o, 32'h0, 4'h1);
    repeat (10) @(posedge mclk_i);
    chk(32'(state[p]), 32'(MDCF_STOPPED));
    chk(32'(fcnt[p]), 32'h3);
    chk(32'(scnt[p]), 32'h3);
    $display("process test %0d done", p);
  endtask

  task automatic filt_test(input logic [5:0] ctl);
    logic [47:0] a;
    logic [31:0] c;
    logic [5:0] ix;
    bus(1'b1, 8'h04, {26'h0, ctl}, 4'h1);
    repeat (8)
    begin
      a = {16'($urandom), $urandom};
      c = MDCF_CRC_INIT;
      for (int i = 0; i < 48; i++)
        c = {c[30:0], 1'b0} ^ ((a[i] ^ c[31]) ? MDCF_CRC_POLY : 32'h0);
      ix = c[31:26];
      @(posedge mclk_i);
      da_valid <= 1'b1;
      da <= a;
      @(posedge mclk_i);
      da_valid <= 1'b0;
      #1;
      chk(32'(fdone), 32'h1);
      chk(32'(fidx), 32'(ix));
      chk(32'(facc), 32'(a[0] & (ctl[2] | ctl[5] | (ctl[1] & mdl[8 + ix[5]][ix[4:0]]))));
    end
    $display("filter test %h done", ctl);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----
  // Clock, counters, sequence
  // ----
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    for (int p = 0; p < 2; p++)
    begin
      fcnt[p] += int'(fetch[p]);
      scnt[p] += int'(spulse[p]);
    end
  end

  initial
  begin
    #(20 * 20000);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    logic [7:0] al [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h3c};
    {rst_i, wb_cyc, wb_stb, wb_we, da_valid} = 5'h10;
    {wb_adr, wb_sel, wb_wdat, da, have} = '0;
    mdl = '{default: 32'h0};
    void'($urandom(47));
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (al[i])
      rdchk(al[i]);
    $display("reset test done");
    proc_test(0);
    proc_test(1);
    bus(1'b1, 8'h20, $urandom, 4'hf);
    bus(1'b1, 8'h24, $urandom, 4'hf);
    rdchk(8'h20);
    rdchk(8'h24);
    foreach (al[i])
      filt_test(6'(al[i] == 8'h3c ? 8'h03 : al[i] >> 1));
    filt_test(6'h20);
    finish_test();
  end
endmodule
`default_nettype wire
